/* File: hw/npic_core.sv */
// Nested priority interrupt controller with entry sequencer and bus slave
//
// Functional notes
// - Codes 10,01,00,11 are levels 0,1,2,3; level 3 masks all.
// - Sixteen vectors fixed from ffe0 to ffff, ordered by priority.
// - Service starts only once the current instruction has ended.
// - Entry pushes program counter, index, accumulator and flags.
// - Maskable entry loads the level bits from the vector's priority.
// - After pushing, the vector address is loaded and fetched.
// - Return restores all stacked flags, level bits included.
// - Highest software priority wins; ties go to hardware order.
// - Unserviced requests stay latched: external ones until they win arbitration, peripheral ones until cleared.
// - Reset and trap ignore the level and force level 3; trap never wakes wait or halt.
// - Reset ranks highest and leaves the code at level 3.
// - Maskable service needs enable set and priority above level.
// - Edge external requests latch and clear on handler entry.
// - Selected pins of a group combine through a NAND.
// - Peripheral request is status flag and its enable both set.
// - Flag clearing sequence drops the waiting request latch.
// - Any request wakes wait; halt only external or halt-capable.
// - Leaving halt serves a halt-capable one first, others next.
// - Level bits writable by mask, unmask, halt, wait, return, pop.
// - Flags reset to 111x 1010.
// - Writing level-0 code to a priority field is ignored.
`timescale 1ns/10ps
`default_nettype none
module npic_core
   import npic_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic instr_end_in,
   input wire logic trap_in,
   input wire logic return_from_service_in,
   input wire logic [7:0] cc_restore_in,
   input wire logic wait_in,
   input wire logic halt_in,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] x_in,
   input wire logic [7:0] a_in,
   input wire logic [npic_pkg::NUM_VEC-1:0] periph_flag_in,
   input wire logic [npic_pkg::NUM_VEC-1:0] periph_flag_en_in,
   input wire logic [npic_pkg::NUM_VEC-1:0] clear_seq_in,
   input wire logic [npic_pkg::NUM_PINS-1:0] ext_pins_in,
   output logic [7:0] condition_code_flags_out,
   output logic stack_we_out,
   output logic [7:0] stack_data_out,
   output logic [15:0] vector_addr_out,
   output logic pc_load_out,
   output logic busy_out,
   output logic sleep_out
);
   import npic_pkg::*;

   npic_state_t state;
   npic_state_t next_state;
   logic [7:0] condition_code_flags;
   logic [13:0] src_enable;
   logic [13:0] halt_cap;
   logic [15:0] pin_sel;
   logic [NUM_PINS-1:0] pin_meta;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_GRP-1:0] grp_req_d;
   logic halt_mode;
   logic [15:0] sv_pc;
   logic [7:0] sv_x;
   logic [7:0] sv_a;
   logic [7:0] sv_cc;
   logic [15:0] sv_vec;
   logic [3:0] last_vec;
   logic last_trap;
   logic [NUM_VEC-1:0] pend;
   logic [1:0] prio [NUM_FIELD];
   logic [1:0] vec_rank [NUM_VEC];
   logic [NUM_VEC-1:0] cand;
   logic best_found;
   logic [3:0] best_idx;
   logic [1:0] best_rank;

   // Maps a priority code to its nesting rank, 0 lowest
   function automatic logic [1:0] lvl_rank(input logic [1:0] code);
      logic [1:0] r;
      r = 2'b00;
      unique case (code)
         LVL0: r = 2'b00;
         LVL1: r = 2'b01;
         LVL2: r = 2'b10;
         LVL3: r = 2'b11;
      endcase
      return r;
   endfunction

   // Bus decode
   wire logic bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic bus_wr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in;
   wire logic hit_cc = wb_adr_in == ADR_CC;
   wire logic hit_status = wb_adr_in == ADR_STATUS;
   wire logic hit_enable = wb_adr_in == ADR_ENABLE;
   wire logic hit_haltcap = wb_adr_in == ADR_HALTCAP;
   wire logic hit_pinsel = wb_adr_in == ADR_PINSEL;
   wire logic hit_pend = wb_adr_in == ADR_PEND;
   wire logic [5:0] word_idx = wb_adr_in[7:2];
   wire logic hit_prio = (wb_adr_in[1:0] == 2'b00) &&
                         (word_idx >= PRIO_IDX0) && (word_idx <= PRIO_IDX3);
   wire logic [1:0] prio_reg = 2'(word_idx - PRIO_IDX0);
   wire logic wr_cc = bus_wr && hit_cc && wb_sel_in[0];
   wire logic wr_prio = bus_wr && hit_prio && wb_sel_in[0];

   // Current level and its rank
   wire logic [1:0] cur_lvl = {condition_code_flags[CC_I1_POS],
                               condition_code_flags[CC_I0_POS]};
   wire logic [1:0] cur_rank = lvl_rank(cur_lvl);

   // Two-flop synchroniser on the external pins
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= ext_pins_in;
         pin_sync <= pin_meta;
      end
   end

   // Group requests: NAND of selected pins, then edge detection
   logic [NUM_GRP-1:0] grp_req;
   logic [NUM_GRP-1:0] grp_edge;
   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++) begin : gen_grp
         assign grp_req[g] = ~&(pin_sync[g*GRP_PINS +: GRP_PINS] |
                                ~pin_sel[g*GRP_PINS +: GRP_PINS]);
         assign grp_edge[g] = grp_req[g] && !grp_req_d[g];
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         grp_req_d <= '0;
      end else begin
         grp_req_d <= grp_req;
      end
   end

   // Entry strobes
   logic take_mask;
   logic take_trap;

   // Per-vector latches and fields
   genvar v;
   generate
      for (v = 0; v < NUM_VEC; v++) begin : gen_vec
         logic set_req;
         logic clr_req;
         if (v < NUM_GRP) begin : gen_ext
            assign set_req = grp_edge[v];
            assign clr_req = take_mask && (best_idx == 4'(v));
         end else begin : gen_per
            assign set_req = periph_flag_in[v] && periph_flag_en_in[v];
            assign clr_req = clear_seq_in[v];
         end
         npic_req_latch u_latch (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .set_in(set_req),
            .clr_in(clr_req),
            .q_out(pend[v])
         );
         npic_prio_field u_prio (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .we_in(wr_prio && (prio_reg == 2'(v / 4))),
            .d_in(wb_dat_in[2*(v % 4) +: 2]),
            .q_out(prio[v])
         );
         assign vec_rank[v] = lvl_rank(prio[v]);
      end
      for (v = NUM_VEC; v < NUM_FIELD; v++) begin : gen_fixed
         assign prio[v] = PRIO_RESET;
      end
   endgenerate

   // Candidate vectors
   wire logic [13:0] halt_wake = halt_cap | EXT_VEC_MASK;
   wire logic in_halt = (state == ST_SLEEP) && halt_mode;
   generate
      for (v = 0; v < NUM_VEC; v++) begin : gen_cand
         assign cand[v] = pend[v] && src_enable[v] &&
                          (vec_rank[v] > cur_rank) &&
                          (!in_halt || halt_wake[v]);
      end
   endgenerate

   // Arbiter, ties to the lowest index
   always_comb begin
      best_found = 1'b0;
      best_idx = 4'h0;
      best_rank = 2'b00;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (cand[i] && (!best_found || vec_rank[i] >= best_rank)) begin
            best_found = 1'b1;
            best_idx = 4'(i);
            best_rank = vec_rank[i];
         end
      end
   end

   // Service start
   wire logic at_boundary = (state == ST_IDLE) && instr_end_in &&
                            !pc_load_out && !return_from_service_in;
   assign take_trap = at_boundary && trap_in;
   assign take_mask = ((at_boundary && !trap_in) || (state == ST_SLEEP)) &&
                      best_found;
   wire logic take = take_trap || take_mask;
   wire logic go_sleep = at_boundary && !take && (wait_in || halt_in);
   wire logic [15:0] best_vec = 16'(VEC_BASE - {11'h000, best_idx, 1'b0});

   // Entry sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_PCL;
            end else if (go_sleep) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (take) begin
               next_state = ST_PCL;
            end
         end
         ST_PCL: next_state = ST_PCH;
         ST_PCH: next_state = ST_X;
         ST_X: next_state = ST_A;
         ST_A: next_state = ST_CC;
         ST_CC: next_state = ST_FETCH;
         ST_FETCH: next_state = ST_IDLE;
      endcase
   end

   // State; reset goes straight to fetch
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_FETCH;
         sv_vec <= VEC_RESET;
         halt_mode <= 1'b0;
      end else begin
         state <= next_state;
         if (take) begin
            sv_vec <= take_trap ? VEC_TRAP : best_vec;
         end
         if (go_sleep) begin
            halt_mode <= halt_in;
         end
      end
   end

   // Context captured at service start
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sv_pc <= 16'h0000;
         sv_x <= 8'h00;
         sv_a <= 8'h00;
         sv_cc <= CC_RESET;
         last_vec <= LAST_VEC_RESET;
         last_trap <= 1'b0;
      end else if (take) begin
         sv_pc <= pc_in;
         sv_x <= x_in;
         sv_a <= a_in;
         sv_cc <= condition_code_flags;
         last_vec <= take_trap ? LAST_VEC_RESET : best_idx;
         last_trap <= take_trap;
      end
   end

   // Condition code flags
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         condition_code_flags <= CC_RESET;
      end else if (return_from_service_in && (state == ST_IDLE)) begin
         condition_code_flags <= {CC_FIXED_ONES, cc_restore_in[5:0]};
      end else if (take_trap) begin
         condition_code_flags[CC_I1_POS] <= LVL3[1];
         condition_code_flags[CC_I0_POS] <= LVL3[0];
      end else if (take_mask) begin
         condition_code_flags[CC_I1_POS] <= prio[best_idx][1];
         condition_code_flags[CC_I0_POS] <= prio[best_idx][0];
      end else if (go_sleep) begin
         condition_code_flags[CC_I1_POS] <= LVL0[1];
         condition_code_flags[CC_I0_POS] <= LVL0[0];
      end else if (wr_cc) begin
         condition_code_flags <= {CC_FIXED_ONES, wb_dat_in[5:0]};
      end
   end

   // Stack push data selected by the current push state
   logic [7:0] push_data;
   always_comb begin
      push_data = 8'h00;
      unique case (state)
         ST_PCL: push_data = sv_pc[7:0];
         ST_PCH: push_data = sv_pc[15:8];
         ST_X: push_data = sv_x;
         ST_A: push_data = sv_a;
         ST_CC: push_data = sv_cc;
         ST_IDLE, ST_FETCH, ST_SLEEP: push_data = 8'h00;
      endcase
   end
   wire logic is_push = (state == ST_PCL) || (state == ST_PCH) ||
                        (state == ST_X) || (state == ST_A) ||
                        (state == ST_CC);

   // Registered core outputs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stack_we_out <= 1'b0;
         stack_data_out <= 8'h00;
         vector_addr_out <= VEC_RESET;
         pc_load_out <= 1'b0;
         busy_out <= 1'b1;
         sleep_out <= 1'b0;
         condition_code_flags_out <= CC_RESET;
      end else begin
         stack_we_out <= is_push;
         stack_data_out <= push_data;
         if (state == ST_FETCH) begin
            vector_addr_out <= sv_vec;
         end
         pc_load_out <= state == ST_FETCH;
         busy_out <= (next_state != ST_IDLE) && (next_state != ST_SLEEP) ||
                     (state == ST_FETCH);
         sleep_out <= next_state == ST_SLEEP;
         condition_code_flags_out <= condition_code_flags;
      end
   end

   // Software-written control registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         src_enable <= ENABLE_RESET;
         halt_cap <= HALTCAP_RESET;
         pin_sel <= PINSEL_RESET;
      end else if (bus_wr) begin
         if (hit_enable && wb_sel_in[0]) src_enable[7:0] <= wb_dat_in[7:0];
         if (hit_enable && wb_sel_in[1]) src_enable[13:8] <= wb_dat_in[13:8];
         if (hit_haltcap && wb_sel_in[0]) halt_cap[7:0] <= wb_dat_in[7:0];
         if (hit_haltcap && wb_sel_in[1]) halt_cap[13:8] <= wb_dat_in[13:8];
         if (hit_pinsel && wb_sel_in[0]) pin_sel[7:0] <= wb_dat_in[7:0];
         if (hit_pinsel && wb_sel_in[1]) pin_sel[15:8] <= wb_dat_in[15:8];
      end
   end

   // Read-back words
   wire logic [7:0] prio_word [4];
   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : gen_rd
         assign prio_word[r] = {prio[4*r+3], prio[4*r+2],
                                prio[4*r+1], prio[4*r]};
      end
   endgenerate
   wire logic [31:0] status_word = {24'h000000, halt_mode,
                                    state == ST_SLEEP,
                                    busy_out, last_trap, last_vec};
   wire logic [31:0] rd_data =
      hit_cc ? {24'h000000, condition_code_flags} :
      hit_status ? status_word :
      hit_enable ? {18'h00000, src_enable} :
      hit_haltcap ? {18'h00000, halt_cap} :
      hit_pinsel ? {16'h0000, pin_sel} :
      hit_pend ? {18'h00000, pend} :
      hit_prio ? {24'h000000, prio_word[prio_reg]} : 32'h00000000;

   // Bus answer one cycle after the request
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= bus_req;
         if (bus_req && !wb_we_in) begin
            wb_dat_out <= rd_data;
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/npic_pkg.sv */
// Constants, register map and state type of the nested interrupt controller
package npic_pkg;
   // Vector set: fourteen maskable vectors plus trap and reset
   localparam int NUM_VEC = 14;
   localparam int NUM_FIELD = 16;
   localparam int NUM_GRP = 2;
   localparam int GRP_PINS = 8;
   localparam int NUM_PINS = NUM_GRP * GRP_PINS;
   // Vector addresses at the top of the address space
   localparam logic [15:0] VEC_TOP = 16'hffff;
   localparam logic [15:0] VEC_BOTTOM = 16'hffe0;
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_TRAP = 16'hfffc;
   localparam logic [15:0] VEC_BASE = 16'hfffa;
   // Condition code flags layout and reset value (undefined bit taken as 0)
   localparam int CC_I1_POS = 5;
   localparam int CC_I0_POS = 3;
   localparam logic [7:0] CC_RESET = 8'hea;
   localparam logic [1:0] CC_FIXED_ONES = 2'b11;
   // Priority codes
   localparam logic [1:0] LVL0 = 2'b10;
   localparam logic [1:0] LVL1 = 2'b01;
   localparam logic [1:0] LVL2 = 2'b00;
   localparam logic [1:0] LVL3 = 2'b11;
   localparam logic [1:0] PRIO_RESET = 2'b11;
   // Register byte addresses on the bus; priority registers as word indices
   localparam logic [7:0] ADR_CC = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_ENABLE = 8'h0c;
   localparam logic [7:0] ADR_HALTCAP = 8'h10;
   localparam logic [7:0] ADR_PINSEL = 8'h14;
   localparam logic [7:0] ADR_PEND = 8'h18;
   localparam logic [5:0] PRIO_IDX0 = 6'h1c;
   localparam logic [5:0] PRIO_IDX3 = 6'h1f;
   // Reset values of the control registers and the external vector mask
   localparam logic [13:0] ENABLE_RESET = 14'h0000;
   localparam logic [13:0] HALTCAP_RESET = 14'h002b;
   localparam logic [13:0] EXT_VEC_MASK = 14'h0003;
   localparam logic [15:0] PINSEL_RESET = 16'h0000;
   localparam logic [3:0] LAST_VEC_RESET = 4'hf;
   // Entry sequencer states, Gray coded along the push path
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PCL = 3'b001,
      ST_PCH = 3'b011,
      ST_X = 3'b010,
      ST_A = 3'b110,
      ST_CC = 3'b111,
      ST_FETCH = 3'b101,
      ST_SLEEP = 3'b100
   } npic_state_t;
endpackage

/* File: hw/npic_prio_field.sv */
// Two-bit software priority field of one vector
`timescale 1ns/10ps
`default_nettype none
module npic_prio_field
   import npic_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic we_in,
   input wire logic [1:0] d_in,
   output logic [1:0] q_out
);
   // The level-0 code is refused and the old value kept
   wire logic accept = we_in && (d_in != LVL0);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= PRIO_RESET;
      end else if (accept) begin
         q_out <= d_in;
      end
   end
endmodule
`default_nettype wire

/* File: hw/npic_req_latch.sv */
// Request latch of one vector: set wins over clear
`timescale 1ns/10ps
`default_nettype none
module npic_req_latch (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic set_in,
   input wire logic clr_in,
   output logic q_out
);
   // Holds the request until cleared; a new event in the clear cycle stays
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= 1'b0;
      end else if (set_in) begin
         q_out <= 1'b1;
      end else if (clr_in) begin
         q_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verif/npic_core_sva.sv */
// Port-level assertion checker for the nested interrupt controller
`timescale 1ns/10ps
`default_nettype none
module npic_core_sva
   import npic_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic instr_end_in,
   input wire logic trap_in,
   input wire logic return_from_service_in,
   input wire logic [7:0] condition_code_flags_out,
   input wire logic stack_we_out,
   input wire logic [15:0] vector_addr_out,
   input wire logic pc_load_out,
   input wire logic busy_out,
   input wire logic sleep_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Trap taken at an idle boundary
   wire trap_go = instr_end_in && trap_in && !return_from_service_in && !busy_out &&
      !pc_load_out && !sleep_out;
   // Entry sequence shape
   stack_run_a: assert property ($rose(stack_we_out) |->
      stack_we_out [*5] ##1 (!stack_we_out && pc_load_out))
      else $error("bad stack burst");
   stack_busy_a: assert property (stack_we_out |->
      busy_out && !sleep_out)
      else $error("stray stacking");
   load_pulse_a: assert property (pc_load_out |=> !pc_load_out)
      else $error("long vector load");
   vec_top_a: assert property (pc_load_out |->
      vector_addr_out >= VEC_BOTTOM && !vector_addr_out[0])
      else $error("vector out of area");
   trap_lvl_a: assert property (trap_go |-> ##[1:3]
      (condition_code_flags_out[5] && condition_code_flags_out[3]))
      else $error("trap level");
   trap_vec_a: assert property (trap_go |-> ##[6:8]
      (pc_load_out && vector_addr_out == VEC_TRAP))
      else $error("trap vector");
   // Bus answer timing and unmapped read data
   ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
      |=> wb_ack_out)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack too long");
   unmap_zero_a: assert property (wb_cyc_in && wb_stb_in && !wb_we_in &&
      !wb_ack_out && wb_adr_in == 8'h04 |=> wb_dat_out == 32'h0)
      else $error("unmapped read");
   // Main scenarios reached
   cover property (trap_go);
   cover property ($rose(stack_we_out));
   cover property ($fell(sleep_out));
endmodule
bind npic_core npic_core_sva chk (.clk_in(clk_in), .rst_in(rst_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .instr_end_in(instr_end_in), .trap_in(trap_in), .return_from_service_in(return_from_service_in),
   .condition_code_flags_out(condition_code_flags_out),
   .stack_we_out(stack_we_out), .vector_addr_out(vector_addr_out),
   .pc_load_out(pc_load_out), .busy_out(busy_out), .sleep_out(sleep_out));
`default_nettype wire

/* File: verif/npic_core_tb.sv */
// Self-checking bench of the controller
`timescale 1ns/10ps
`default_nettype none
module npic_core_tb;
   import npic_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
   logic wb_we_in = 1'b0, trap_in = 1'b0, return_from_service_in = 1'b0, wait_in = 1'b0;
   logic halt_in = 1'b0, busy_d = 1'b0;
   logic [7:0] wb_adr_in = 8'h00, cc_restore_in = 8'h00;
   logic [3:0] wb_sel_in = 4'hf;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic [NUM_VEC-1:0] periph_flag_in = '0, periph_flag_en_in = '0;
   logic [NUM_VEC-1:0] clear_seq_in = '0, pend = '0;
   logic [NUM_PINS-1:0] ext_pins_in = '1;
   logic wb_ack_out, instr_end_in, stack_we_out, pc_load_out;
   logic busy_out, sleep_out;
   logic [7:0] x_in, a_in, condition_code_flags_out, stack_data_out, cur_cc;
   logic [15:0] pc_in, vector_addr_out;
   logic [7:0] preg [4], stk_q [$], cc_stk [$];
   logic [15:0] vec_q [$];
   logic [31:0] ctx_q [$];
   logic [7:0] ra [10] = '{ADR_CC, 8'h04, ADR_ENABLE, ADR_HALTCAP,
      ADR_PINSEL, ADR_PEND, 8'h70, 8'h74, 8'h78, 8'h7c};
   logic [31:0] rv [10] = '{32'hea, 32'h0, 32'h0, 32'h2b, 32'h0, 32'h0,
      32'hff, 32'hff, 32'hff, 32'hff};
   int bad_count = 0, compares = 0, v;
   npic_core uut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
      .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .instr_end_in(instr_end_in), .trap_in(trap_in),
      .return_from_service_in(return_from_service_in), .cc_restore_in(cc_restore_in), .wait_in(wait_in),
      .halt_in(halt_in), .pc_in(pc_in), .x_in(x_in), .a_in(a_in),
      .periph_flag_in(periph_flag_in), .periph_flag_en_in(periph_flag_en_in),
      .clear_seq_in(clear_seq_in), .ext_pins_in(ext_pins_in),
      .condition_code_flags_out(condition_code_flags_out),
      .stack_we_out(stack_we_out), .stack_data_out(stack_data_out),
      .vector_addr_out(vector_addr_out), .pc_load_out(pc_load_out),
      .busy_out(busy_out), .sleep_out(sleep_out));
   npic_cpu_model core (.clk_in(clk_in), .rst_in(rst_in), .busy_in(busy_out),
      .pc_load_in(pc_load_out), .instr_end_out(instr_end_in), .pc_out(pc_in),
      .x_out(x_in), .a_out(a_in));
   // Clock generator
   initial forever #25 clk_in = ~clk_in;
   // Record pushes, vector loads, entry context
   always @(posedge clk_in) begin
      if (stack_we_out === 1'b1) stk_q.push_back(stack_data_out);
      if (pc_load_out === 1'b1) vec_q.push_back(vector_addr_out);
      if (busy_out === 1'b1 && !busy_d) ctx_q.push_back({pc_in, x_in, a_in});
      busy_d <= busy_out;
   end
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic chk_ent(input logic [15:0] got, input logic [15:0] exp);
      chk_reg({16'h0, got}, {16'h0, exp});
   endtask
   // Classic Wishbone cycle
   task automatic wb(input logic we, input logic [7:0] adr,
         input logic [31:0] d, output logic [31:0] rq);
      int n = 0;
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_dat_in <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 40);
      rq = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      if (n >= 40) bad_count++;
   endtask
   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, q);
      chk_reg(q, exp);
   endtask
   task automatic wprio(input int r, input logic [7:0] d);
      wb(1'b1, {PRIO_IDX0 + 6'(r), 2'b00}, {24'h0, d}, q);
      for (int k = 0; k < 4; k++)
         if (d[2*k +: 2] != LVL0) preg[r][2*k +: 2] = d[2*k +: 2];
   endtask
   function automatic int rank(logic [1:0] c);
      return (c == LVL0) ? 0 : (c == LVL1) ? 1 : (c == LVL2) ? 2 : 3;
   endfunction
   function automatic logic [1:0] fld(int i);
      return preg[i / 4][2 * (i % 4) +: 2];
   endfunction
   // Reference arbitration
   function automatic int pick(logic [13:0] ok);
      int b;
      b = -1;
      for (int i = 0; i < NUM_VEC; i++)
         if (pend[i] && ok[i] && rank(fld(i)) > rank({cur_cc[5], cur_cc[3]})
            && (b < 0 || rank(fld(i)) > rank(fld(b))))
            b = i;
      return b;
   endfunction
   task automatic entry(input logic [15:0] vec, input logic [1:0] lvl);
      logic [31:0] c;
      logic [39:0] e;
      int n = 0;
      while (vec_q.size() == 0 && n < 60) begin
         @(posedge clk_in);
         n++;
      end
      c = ctx_q.pop_front();
      e = {c[23:16], c[31:24], c[15:8], c[7:0], cur_cc};
      chk_ent(vec_q.pop_front(), vec);
      for (int k = 4; k >= 0; k--)
         chk_ent({8'h00, stk_q.pop_front()}, {8'h00, e[8*k +: 8]});
      cc_stk.push_back(cur_cc);
      cur_cc[5] = lvl[1];
      cur_cc[3] = lvl[0];
      chk_reg(32'(condition_code_flags_out), 32'(cur_cc));
   endtask
   task automatic drop(input int i);
      @(posedge clk_in);
      periph_flag_in[i] <= 1'b0;
      clear_seq_in[i] <= 1'b1;
      @(posedge clk_in);
      clear_seq_in[i] <= 1'b0;
      pend[i] = 1'b0;
   endtask
   task automatic ret();
      cur_cc = cc_stk.pop_back();
      @(posedge clk_in);
      return_from_service_in <= 1'b1;
      cc_restore_in <= cur_cc;
      @(posedge clk_in);
      return_from_service_in <= 1'b0;
   endtask
   task automatic final_report();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      final_report();
   end
   // Main sequence
   initial begin
      cur_cc = CC_RESET;
      preg = '{default: 8'hff};
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk_ent(vec_q.pop_front(), VEC_RESET);
      ctx_q.delete();
      foreach (ra[i]) rdc(ra[i], rv[i]);
      wprio(0, 8'hcf);
      wprio(0, 8'h64);
      rdc(8'h70, {24'h0, preg[0]});
      wb(1'b1, ADR_CC, 32'h20, q);
      cur_cc = 8'he0;
      @(posedge clk_in);
      trap_in <= 1'b1;
      @(posedge clk_in);
      trap_in <= 1'b0;
      entry(VEC_TRAP, LVL3);
      ret();
      wprio(0, 8'h4f);
      wprio(1, 8'hfc);
      wb(1'b1, ADR_ENABLE, 32'h1d, q);
      periph_flag_en_in <= '1;
      periph_flag_in <= 14'h001c;
      pend = 14'h001c;
      repeat (3) begin
         v = pick(14'h3fff);
         entry(VEC_BASE - 16'(2 * v), fld(v));
         drop(v);
         rdc(ADR_PEND, {18'h0, pend});
         ret();
      end
      wb(1'b1, ADR_PINSEL, 32'h1, q);
      ext_pins_in[0] <= 1'b0;
      pend[0] = 1'b1;
      v = pick(14'h3fff);
      entry(VEC_BASE - 16'(2 * v), fld(v));
      rdc(ADR_PEND, 32'h0);
      ext_pins_in[0] <= 1'b1;
      pend[0] = 1'b0;
      ret();
      @(posedge clk_in);
      halt_in <= 1'b1;
      @(posedge clk_in);
      halt_in <= 1'b0;
      periph_flag_in[4] <= 1'b1;
      pend[4] = 1'b1;
      repeat (10) @(posedge clk_in);
      chk_reg({31'h0, sleep_out}, 32'h1);
      periph_flag_in[3] <= 1'b1;
      pend[3] = 1'b1;
      v = pick(HALTCAP_RESET);
      entry(VEC_BASE - 16'(2 * v), fld(v));
      v = pick(14'h3fff);
      entry(VEC_BASE - 16'(2 * v), fld(v));
      drop(4);
      ret();
      drop(3);
      ret();
      rdc(ADR_PEND, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire

/* File: verif/npic_cpu_model.sv */
// Behavioural core model
`timescale 1ns/10ps
`default_nettype none
module npic_cpu_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic busy_in,
   input wire logic pc_load_in,
   output logic instr_end_out,
   output logic [15:0] pc_out,
   output logic [7:0] x_out,
   output logic [7:0] a_out
);
   integer seed = 12;
   integer r;
   // Ends an instruction every free cycle
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         instr_end_out <= 1'b0;
      end else begin
         instr_end_out <= !busy_in && !pc_load_in;
      end
   end
   // Fresh context per vector load
   always @(posedge clk_in) begin
      if (pc_load_in || rst_in) begin
         r = $random(seed);
         pc_out <= r[15:0];
         {x_out, a_out} <= r[31:16];
      end
   end
endmodule
`default_nettype wire
